// ==== verilog/iex_pkg.sv ====
// Package for the instruction execute block: opcodes, field layouts, resets.
// Assumes a 14-bit instruction word presented by a fetch stage on clk.
package iex_pkg;

    localparam int IW_W       = 14;
    localparam int PC_W       = 15;
    localparam int FADDR_W    = 7;
    localparam int DADDR_W    = 16;
    localparam int PTR_MSB    = 15;
    localparam int LATCH_W    = 7;
    localparam int BANK_W     = 6;
    localparam int JMP_W      = 11;
    localparam int OFS_W      = 6;
    localparam int DEST_BIT   = 7;
    localparam int BIT_LSB    = 7;
    localparam int PTR_SEL    = 2;
    localparam int CLR_SEL    = 7;

    localparam logic [7:0]       ACC_RST   = 8'h00;
    localparam logic [15:0]      PTR_RST   = 16'h0000;
    localparam logic [6:0]       LATCH_RST = 7'h00;
    localparam logic [5:0]       BANK_RST  = 6'h00;
    localparam logic [14:0]      PC_RST    = 15'h0000;
    localparam int               MEM_AW    = 8;

    // Indirect pointer modes
    localparam logic [1:0] PM_PRE_INC  = 2'h0;
    localparam logic [1:0] PM_PRE_DEC  = 2'h1;
    localparam logic [1:0] PM_POST_INC = 2'h2;
    localparam logic [1:0] PM_POST_DEC = 2'h3;

    typedef enum logic [3:0] {
        IEX_EXEC  = 4'h1,
        IEX_NOP   = 4'h2,
        IEX_EXTRA = 4'h4,
        IEX_WB    = 4'h8
    } iex_state_e;

    typedef enum logic [4:0] {
        OP_NOP, OP_BIT_SKIP_ONE, OP_CALL, OP_COMPUTED_SUBROUTINE_JUMP, OP_WDT_CLR, OP_INVERT,
        OP_ZERO_F, OP_ZERO_W, OP_DEC, OP_DEC_SKIP, OP_JUMP, OP_INC_SKIP,
        OP_INC, OP_OR_LIT, OP_OR_F, OP_SHL, OP_SHR, OP_COPY_F, OP_IND_MODE,
        OP_IND_OFS, OP_BANK_LIT, OP_PAGE_LIT, OP_LIT_W, OP_STORE_W
    } iex_op_e;

    typedef struct packed {
        logic [7:0]  data;
        logic        zero;
        logic        carry;
        logic        zero_we;
        logic        carry_we;
    } iex_alu_s;

    typedef struct packed {
        logic                 push;
        logic [PC_W-1:0]      ret_addr;
        logic                 pc_load;
        logic [PC_W-1:0]      pc_value;
    } iex_flow_s;

endpackage

// ==== verilog/iex_decode.sv ====
// Instruction classifier for the execute block.
// Assumes a full 14-bit instruction word; unknown words decode to no-op.
`timescale 1ns/1ns
module iex_decode
    import iex_pkg::*;
(
    input  wire logic [iex_pkg::IW_W-1:0] instr,
    output iex_pkg::iex_op_e              op
);

    always_comb begin
        op = OP_NOP;
        casez (instr)
            14'b01_11??_????_????: op = OP_BIT_SKIP_ONE;
            14'b10_0???_????_????: op = OP_CALL;
            14'b10_1???_????_????: op = OP_JUMP;
            14'b00_0000_0000_1010: op = OP_COMPUTED_SUBROUTINE_JUMP;
            14'b00_0000_0110_0100: op = OP_WDT_CLR;
            14'b00_1001_????_????: op = OP_INVERT;
            14'b00_0001_1???_????: op = OP_ZERO_F;
            14'b00_0001_0000_00??: op = OP_ZERO_W;
            14'b00_0011_????_????: op = OP_DEC;
            14'b00_1011_????_????: op = OP_DEC_SKIP;
            14'b00_1111_????_????: op = OP_INC_SKIP;
            14'b00_1010_????_????: op = OP_INC;
            14'b11_1000_????_????: op = OP_OR_LIT;
            14'b00_0100_????_????: op = OP_OR_F;
            14'b11_0101_????_????: op = OP_SHL;
            14'b11_0110_????_????: op = OP_SHR;
            14'b00_1000_????_????: op = OP_COPY_F;
            14'b00_0000_0001_0???: op = OP_IND_MODE;
            14'b11_1111_0???_????: op = OP_IND_OFS;
            14'b00_0000_001?_????: op = OP_BANK_LIT;
            14'b11_0001_1???_????: op = OP_PAGE_LIT;
            14'b11_0000_????_????: op = OP_LIT_W;
            14'b00_0000_1???_????: op = OP_STORE_W;
            default:               op = OP_NOP;
        endcase
    end

endmodule

// ==== verilog/iex_mem.sv ====
// Small data memory reached through the indirect pointers.
// Assumes one access per cycle; read data come from a register.
`timescale 1ns/1ns
module iex_mem #(
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          we,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);

    logic [7:0] store [2**AW];

    // No reset: contents are undefined until written
    always_ff @(posedge clk) begin
        if (we) begin
            store[addr] <= wdata;
        end
        rdata <= store[addr];
    end

endmodule

// ==== verilog/iex_core.sv ====
// Contract
// RL1: Bit-one test skips next instruction, two cycles
// RL2: Call pushes return, operand plus latch 6:3
// RL3: Computed call uses accumulator and latch 6:0
// RL4: Watchdog clear zeroes counter, sets both flags
// RL5: Destination bit picks accumulator or file
// RL6: Invert file, route by destination, zero flag
// RL7: Clear file or accumulator, zero flag set
// RL8: Decrement, store, skip on zero, flags kept
// RL9: Increment, store, skip on zero, flags kept
// RL10: Jump loads operand, latch upper, no push
// RL11: OR literal or file, zero flag updated
// RL12: Left shift: bit 7 to carry, zero in
// RL13: Right shift: bit 0 to carry, zero in
// RL14: Four pointer modes plus signed offset form
// RL15: Indirect load copies memory to accumulator
// RL16: Pointers wrap within sixteen bits
// RL17: Bank literal load, flags untouched
// RL18: Page literal load into high latch
// RL19: Literal to accumulator, one cycle, flags kept
// RL20: Store accumulator to file, one cycle
// RL21: Program counter change or skip adds NOP cycle
// RL22: Pointer top bit set adds one cycle
// RL23: Jump upper bits from latch 6:3
// RL24: Zero flag equals result equals zero
//
// Execute stage of the core. Holds accumulator, flags, latches, pointers.
// Assumes the fetch stage presents instr with instr_valid and obeys busy;
// file reads return combinationally on file_rdata for file_addr.
`timescale 1ns/1ns
module iex_core
    import iex_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        instr_valid,
    input  wire logic [iex_pkg::IW_W-1:0]    instr,
    input  wire logic [iex_pkg::PC_W-1:0]    pc,
    input  wire logic [7:0]                  file_rdata,
    output logic      [iex_pkg::FADDR_W-1:0] file_addr,
    output logic                             file_we,
    output logic      [7:0]                  file_wdata,
    output logic                             busy,
    output iex_pkg::iex_flow_s               flow,
    output logic                             wdt_clear,
    output logic      [7:0]                  acc,
    output logic                             zero_flag,
    output logic                             carry_flag,
    output logic                             timeout_status_flag,
    output logic                             power_down_flag,
    output logic      [iex_pkg::LATCH_W-1:0] program_counter_high_latch,
    output logic      [iex_pkg::BANK_W-1:0]  bank_select_value,
    output logic      [15:0]                 indirect_pointer0,
    output logic      [15:0]                 indirect_pointer1
);
    import iex_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        iex_state_e          state;
        logic [7:0]          acc;
        logic                zero;
        logic                carry;
        logic                to_flag;
        logic                pd_flag;
        logic [LATCH_W-1:0]  latch;
        logic [BANK_W-1:0]   bank;
        logic [1:0][15:0]    ptr;
        logic [15:0]         ind_ea;
        logic                wdt_clr;
        iex_flow_s           flow;
    } iex_core_s;

    iex_core_s  r;
    iex_core_s  next_r;
    iex_op_e    op;
    iex_alu_s   alu;
    logic [7:0] mem_rdata;
    logic [15:0] ind_addr;
    logic        ind_mem_go;
    logic        ptr_sel;

    // Offset form names its pointer just above the offset field
    assign ptr_sel = (op == OP_IND_OFS) ? instr[OFS_W] : instr[PTR_SEL];

    iex_decode u_decode (
        .instr (instr),
        .op    (op)
    );

    iex_mem #(.AW(MEM_AW)) u_mem (
        .clk   (clk),
        .addr  (ind_addr[MEM_AW-1:0]),
        .we    (1'b0),
        .wdata (8'h00),
        .rdata (mem_rdata)
    );

    function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic dec);
        step_ptr = dec ? p - 16'h0001 : p + 16'h0001; // RL16
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic and logic result for file operations
    always_comb begin
        logic [7:0] f;
        f = file_rdata;
        alu = '0;
        case (op)
            OP_INVERT:   alu.data = ~f; // RL6
            OP_DEC:      alu.data = f - 8'h01;
            OP_DEC_SKIP: alu.data = f - 8'h01; // RL8
            OP_INC:      alu.data = f + 8'h01;
            OP_INC_SKIP: alu.data = f + 8'h01; // RL9
            OP_OR_F:     alu.data = r.acc | f; // RL11
            OP_OR_LIT:   alu.data = r.acc | instr[7:0]; // RL11
            OP_SHL: begin
                alu.data     = {f[6:0], 1'b0}; // RL12
                alu.carry    = f[7];
                alu.carry_we = 1'b1;
            end
            OP_SHR: begin
                alu.data     = {1'b0, f[7:1]}; // RL13
                alu.carry    = f[0];
                alu.carry_we = 1'b1;
            end
            OP_COPY_F:   alu.data = f;
            default:     alu.data = 8'h00;
        endcase
        alu.zero = (alu.data == 8'h00); // RL24
        alu.zero_we = (op inside {OP_INVERT, OP_DEC, OP_INC, OP_OR_F, OP_OR_LIT,
                                  OP_SHL, OP_SHR, OP_COPY_F});
    end

    ////////////////////////////////////////////////////////////////////////
    // Indirect effective address, shared by the memory and the held copy in r.ind_ea
    always_comb begin
        logic [15:0] p;
        p = r.ptr[ptr_sel];
        ind_addr = p;
        ind_mem_go = 1'b0;
        if (r.state == IEX_EXEC && instr_valid) begin
            if (op == OP_IND_MODE) begin
                ind_mem_go = 1'b1;
                case (instr[1:0])
                    PM_PRE_INC:  ind_addr = step_ptr(p, 1'b0); // RL14
                    PM_PRE_DEC:  ind_addr = step_ptr(p, 1'b1);
                    default:     ind_addr = p;
                endcase
            end else if (op == OP_IND_OFS) begin
                ind_mem_go = 1'b1;
                ind_addr = p + {{(16-OFS_W){instr[OFS_W-1]}}, instr[OFS_W-1:0]}; // RL14
            end
        end else begin
            // Taken address held: the pointer may already have stepped
            ind_addr = r.ind_ea;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [PC_W-1:0] ret;
        logic            skip;
        logic            sel;
        next_r          = r;
        next_r.wdt_clr  = 1'b0;
        next_r.flow     = '0;
        file_addr       = instr[FADDR_W-1:0];
        file_we         = 1'b0;
        file_wdata      = alu.data;
        ret             = pc + 15'h0001;
        skip            = 1'b0;
        sel             = ptr_sel;
        case (r.state)
            IEX_EXEC: begin
                if (instr_valid) begin
                    if (alu.zero_we) begin
                        next_r.zero = alu.zero; // RL24
                    end
                    if (alu.carry_we) begin
                        next_r.carry = alu.carry;
                    end
                    case (op)
                        OP_BIT_SKIP_ONE: skip = file_rdata[instr[BIT_LSB +: 3]]; // RL1
                        OP_CALL: begin
                            next_r.flow.push     = 1'b1; // RL2
                            next_r.flow.ret_addr = ret;
                            next_r.flow.pc_load  = 1'b1;
                            next_r.flow.pc_value = {r.latch[6:3], instr[JMP_W-1:0]};
                        end
                        OP_COMPUTED_SUBROUTINE_JUMP: begin
                            next_r.flow.push     = 1'b1; // RL3
                            next_r.flow.ret_addr = ret;
                            next_r.flow.pc_load  = 1'b1;
                            next_r.flow.pc_value = {r.latch, r.acc};
                        end
                        OP_JUMP: begin
                            next_r.flow.pc_load  = 1'b1; // RL10
                            next_r.flow.pc_value = {r.latch[6:3], instr[JMP_W-1:0]}; // RL23
                        end
                        OP_WDT_CLR: begin
                            next_r.wdt_clr = 1'b1; // RL4
                            next_r.to_flag = 1'b1;
                            next_r.pd_flag = 1'b1;
                        end
                        OP_ZERO_F: begin
                            file_we     = 1'b1; // RL7
                            file_wdata  = 8'h00;
                            next_r.zero = 1'b1;
                        end
                        OP_ZERO_W: begin
                            next_r.acc  = 8'h00; // RL7
                            next_r.zero = 1'b1;
                        end
                        OP_INVERT, OP_DEC, OP_INC, OP_OR_F, OP_SHL, OP_SHR, OP_COPY_F,
                        OP_DEC_SKIP, OP_INC_SKIP: begin
                            if (instr[DEST_BIT]) begin
                                file_we = 1'b1; // RL5
                            end else begin
                                next_r.acc = alu.data; // RL5
                            end
                            if (op inside {OP_DEC_SKIP, OP_INC_SKIP}) begin
                                skip = alu.zero; // RL8 RL9
                            end
                        end
                        OP_OR_LIT:   next_r.acc = alu.data; // RL11
                        OP_IND_MODE, OP_IND_OFS: begin
                            next_r.ind_ea   = ind_addr; // RL15
                            if (op == OP_IND_MODE) begin
                                next_r.ptr[sel] = step_ptr(r.ptr[sel], instr[0]); // RL14 RL16
                            end
                        end
                        OP_BANK_LIT: next_r.bank  = instr[BANK_W-1:0]; // RL17
                        OP_PAGE_LIT: next_r.latch = instr[LATCH_W-1:0]; // RL18
                        OP_LIT_W:    next_r.acc   = instr[7:0]; // RL19
                        OP_STORE_W: begin
                            file_we    = 1'b1; // RL20
                            file_wdata = r.acc;
                        end
                        default: ;
                    endcase
                    if (ind_mem_go) begin
                        next_r.state = r.ptr[sel][PTR_MSB] ? IEX_EXTRA : IEX_WB; // RL22
                    end else if (skip || next_r.flow.pc_load) begin
                        next_r.state = IEX_NOP; // RL21
                    end
                end
            end
            IEX_NOP:   next_r.state = IEX_EXEC; // RL21
            IEX_EXTRA: next_r.state = IEX_WB; // RL22
            IEX_WB: begin
                next_r.acc   = mem_rdata; // RL15
                next_r.zero  = (mem_rdata == 8'h00); // RL15 RL24
                next_r.state = IEX_EXEC;
            end
            default: next_r.state = IEX_EXEC;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r         <= '0;
            r.state   <= IEX_EXEC;
            r.acc     <= ACC_RST;
            r.latch   <= LATCH_RST;
            r.bank    <= BANK_RST;
            r.ptr     <= {PTR_RST, PTR_RST};
            r.to_flag <= 1'b1;
            r.pd_flag <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Busy holds fetch during NOP, extra and writeback cycles
    assign busy                       = (r.state != IEX_EXEC);
    assign flow                       = r.flow;
    assign wdt_clear                  = r.wdt_clr;
    assign acc                        = r.acc;
    assign zero_flag                  = r.zero;
    assign carry_flag                 = r.carry;
    assign timeout_status_flag        = r.to_flag;
    assign power_down_flag            = r.pd_flag;
    assign program_counter_high_latch = r.latch;
    assign bank_select_value          = r.bank;
    assign indirect_pointer0          = r.ptr[0];
    assign indirect_pointer1          = r.ptr[1];

endmodule

// ==== test/iex_core_asserts.sv ====
// Checker for the execute block: result, target and timing relations.
// Assumes a bind onto iex_core; one clock, synchronous active-low reset.
`timescale 1ns/1ns
module iex_core_chk
    import iex_pkg::*;
(
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               instr_valid,
    input wire logic [13:0]        instr,
    input wire logic [14:0]        pc,
    input wire logic [7:0]         file_rdata,
    input wire logic [6:0]         file_addr,
    input wire logic               file_we,
    input wire logic [7:0]         file_wdata,
    input wire logic               busy,
    input wire iex_pkg::iex_flow_s flow,
    input wire logic [7:0]         acc,
    input wire logic               zero_flag,
    input wire logic               carry_flag,
    input wire logic [6:0]         program_counter_high_latch,
    input wire logic [15:0]        indirect_pointer0
);
    logic       take;
    logic [6:0] lat;
    assign take = instr_valid && !busy;
    assign lat = program_counter_high_latch;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////
    sequence s_clr_wr;
        file_we && file_wdata == 8'h00 ##1 zero_flag;
    endsequence
    sequence s_nop_slot;
        busy ##1 !flow.pc_load;
    endsequence
    property p_lit;
        take && instr[13:8] == 6'h30 |=> acc == $past(instr[7:0]) && $stable(zero_flag);
    endproperty
    a_lit: assert property (p_lit) else $error("literal load wrong");
    property p_store;
        take && instr[13:7] == 7'h01 |-> file_we && file_wdata == acc && file_addr == instr[6:0];
    endproperty
    a_store: assert property (p_store) else $error("store wrong");
    property p_zero_file_op;
        take && instr[13:7] == 7'h03 |-> s_clr_wr;
    endproperty
    a_zero_file_op: assert property (p_zero_file_op) else $error("clear file wrong");
    property p_shl;
        take && instr[13:8] == 6'h35 |=> carry_flag == $past(file_rdata[7])
            && zero_flag == ($past(file_rdata[6:0]) == 7'h00);
    endproperty
    a_shl: assert property (p_shl) else $error("left shift flags wrong");
    property p_page;
        take && instr[13:7] == 7'h63 |=> lat == $past(instr[6:0]);
    endproperty
    a_page: assert property (p_page) else $error("page latch wrong");
    property p_call;
        flow.pc_load && $past(instr[13:11]) == 3'b100
            |-> flow.push && flow.pc_value == {$past(lat[6:3]), $past(instr[10:0])};
    endproperty
    a_call: assert property (p_call) else $error("call target wrong");
    property p_jump;
        flow.pc_load && $past(instr[13:11]) == 3'b101
            |-> !flow.push && flow.pc_value == {$past(lat[6:3]), $past(instr[10:0])};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_computed_subroutine_jump;
        flow.pc_load && $past(instr) == 14'h000a
            |-> flow.push && flow.pc_value == {$past(lat), $past(acc)};
    endproperty
    a_computed_subroutine_jump: assert property (p_computed_subroutine_jump) else $error("computed call wrong");
    property p_nop;
        flow.pc_load |-> flow.ret_addr == $past(pc) + 15'h0001 || !flow.push ##0 s_nop_slot;
    endproperty
    a_nop: assert property (p_nop) else $error("second cycle wrong");
    property p_wrap;
        $changed(indirect_pointer0) |-> indirect_pointer0 == $past(indirect_pointer0) + 16'h0001
            || indirect_pointer0 == $past(indirect_pointer0) - 16'h0001;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer step wrong");
endmodule
bind iex_core iex_core_chk u_chk (.clk, .rstn, .instr_valid, .instr, .pc, .file_rdata,
    .file_addr, .file_we, .file_wdata, .busy, .flow, .acc, .zero_flag, .carry_flag,
    .program_counter_high_latch, .indirect_pointer0);

// ==== test/iex_core_tb_top.sv ====
// Bench for the execute block: plays the fetch stage and the file memory.
// Assumes combinational file reads and results one cycle after the take.
`timescale 1ns/1ns
module iex_core_tb_top;
    import iex_pkg::*;
    typedef struct {int due; int kind; logic [32:0] val;} iex_note_s;
    logic        clk, rstn, instr_valid, file_we, busy, wdt_clear;
    logic        zero_flag, carry_flag, timeout_status_flag, power_down_flag;
    logic [13:0] instr, w;
    logic [14:0] pc, cur_pc;
    logic [7:0]  file_rdata, file_wdata, acc, e_acc, k, v, r;
    logic [6:0]  file_addr, program_counter_high_latch, e_lat, f;
    logic [5:0]  bank_select_value;
    logic [15:0] indirect_pointer0, indirect_pointer1, old, a;
    logic [15:0] e_p [2];
    logic        e_z, e_c, d, n;
    logic [10:0] jk;
    iex_flow_s   flow;
    logic [7:0]  fmem [128];
    logic [7:0]  sf [128];
    iex_note_s   q [$];
    int          cyc, t, miscompares, checks_done;
    logic [13:0] bops [7] = '{14'h0900, 14'h0300, 14'h0a00, 14'h0400, 14'h0800, 14'h3500, 14'h3600};
    logic [13:0] iws [10] = '{14'h0013, 14'h0010, 14'h0011, 14'h0012, 14'h3f05,
                              14'h0015, 14'h0017, 14'h3f41, 14'h0014, 14'h0016};

    iex_core DUT (.clk, .rstn, .instr_valid, .instr, .pc, .file_rdata, .file_addr, .file_we,
        .file_wdata, .busy, .flow, .wdt_clear, .acc, .zero_flag, .carry_flag,
        .timeout_status_flag, .power_down_flag, .program_counter_high_latch,
        .bank_select_value, .indirect_pointer0, .indirect_pointer1);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    assign file_rdata = fmem[file_addr];
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (file_we) fmem[file_addr] <= file_wdata;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [32:0] obs(input int kd);
        case (kd)
            0: return 33'({zero_flag, carry_flag, acc});
            1: return file_we ? 33'({1'b1, file_addr, file_wdata}) : 33'h0;
            2: return 33'({flow.push, flow.push ? flow.ret_addr : 15'h0, flow.pc_load,
                           flow.pc_value});
            3: return 33'({busy, wdt_clear, timeout_status_flag, power_down_flag});
            4: return 33'({indirect_pointer1, indirect_pointer0});
            6: return 33'(bank_select_value);
            default: return 33'(program_counter_high_latch);
        endcase
    endfunction
    // Notes fall due in order, so the head is always the next result
    always @(negedge clk) begin
        iex_note_s nt;
        while (q.size() > 0 && q[0].due <= cyc) begin
            nt = q.pop_front();
            chk(obs(nt.kind), nt.val);
        end
    end
    task automatic note(input int due, input int kd, input logic [32:0] val);
        q.push_back('{due, kd, val});
    endtask
    task automatic issue(input logic [13:0] word);
        @(posedge clk);
        t = cyc + 1;
        cur_pc = 15'($urandom);
        instr_valid <= 1'b1;
        instr <= word;
        pc <= cur_pc;
    endtask
    // Random words while invalid must never be taken
    task automatic idle(input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            instr_valid <= 1'b0;
            instr <= 14'($urandom);
        end
    endtask
    task automatic post(input logic [15:0] fx, input logic [3:0] m);
        note(t, 1, 33'(fx));
        note(t + 1, 0, 33'({e_z, e_c, e_acc}));
        note(t + 1, 3, 33'(m));
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(65112));
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        pc = 15'h0000;
        {e_acc, e_z, e_c} = 10'h000;
        e_p = '{16'h0000, 16'h0000};
        for (int i = 0; i < 128; i++) begin
            sf[i] = (i == 1) ? 8'h01 : (i == 2) ? 8'hff : (i == 5) ? 8'ha5 : 8'($urandom);
            fmem[i] = sf[i];
        end
        // Known pattern behind the pointers so indirect loads can be judged
        for (int i = 0; i < 256; i++) DUT.u_mem.store[i] = 8'(i * 37);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            k = (i < 2) ? 8'h00 : 8'($urandom);
            e_acc = i[0] ? (e_acc | k) : k;
            if (i[0]) e_z = (e_acc == 8'h00);
            issue(i[0] ? {6'h38, k} : {6'h30, k});
            post(16'h0, 4'h3);
        end
        for (int j = 0; j < 4; j++) begin
            f = (j < 2) ? 7'(1 + j) : 7'(10 + j);
            d = !j[1];
            r = j[0] ? sf[f] + 8'h01 : sf[f] - 8'h01;
            if (d) sf[f] = r;
            else e_acc = r;
            issue((j[0] ? 14'h0f00 : 14'h0b00) | 14'({d, f}));
            post(d ? {1'b1, f, r} : 16'h0, {r == 8'h00, 3'b011});
            if (r == 8'h00) idle(1);
        end
        for (int b = 0; b < 8; b++) begin
            issue(14'h1c05 | 14'(b << 7));
            post(16'h0, {sf[5][b], 3'b011});
            if (sf[5][b]) idle(1);
        end
        for (int i = 0; i < 28; i++) begin
            f = 7'($urandom);
            d = i[0];
            v = sf[f];
            case (i % 7)
                0: r = ~v;
                1: r = v - 8'h01;
                2: r = v + 8'h01;
                3: r = v | e_acc;
                4: r = v;
                5: r = {v[6:0], 1'b0};
                default: r = {1'b0, v[7:1]};
            endcase
            if (i % 7 == 5) e_c = v[7];
            if (i % 7 == 6) e_c = v[0];
            e_z = (r == 8'h00);
            if (d) sf[f] = r;
            else e_acc = r;
            issue(bops[i % 7] | 14'({d, f}));
            post(d ? {1'b1, f, r} : 16'h0, 4'h3);
        end
        {e_acc, e_z} = 9'h001;
        issue(14'h0100);
        post(16'h0, 4'h3);
        f = 7'($urandom);
        issue({7'h03, f});
        post({1'b1, f, 8'h00}, 4'h3);
        e_acc = 8'($urandom);
        issue({6'h30, e_acc});
        post(16'h0, 4'h3);
        issue({7'h01, f});
        post({1'b1, f, e_acc}, 4'h3);
        e_lat = 7'($urandom);
        issue({7'h63, e_lat});
        post(16'h0, 4'h3);
        note(t + 1, 5, 33'(e_lat));
        jk = 11'($urandom);
        issue({3'b100, jk});
        post(16'h0, 4'hb);
        note(t + 1, 2, 33'({1'b1, cur_pc + 15'h1, 1'b1, e_lat[6:3], jk}));
        // Offered during the dead cycle; acc must stay put
        issue(14'h305a);
        issue({3'b101, ~jk});
        post(16'h0, 4'hb);
        note(t + 1, 2, 33'({17'h00001, e_lat[6:3], ~jk}));
        idle(1);
        issue(14'h000a);
        post(16'h0, 4'hb);
        note(t + 1, 2, 33'({1'b1, cur_pc + 15'h1, 1'b1, e_lat, e_acc}));
        idle(1);
        issue(14'h0064);
        post(16'h0, 4'h7);
        // Bank form of the decoder keeps bit 5 set
        k = 8'($urandom) | 8'h20;
        issue({8'h00, k[5:0]});
        post(16'h0, 4'h3);
        note(t + 1, 6, 33'(k[5:0]));
        for (int i = 0; i < 10; i++) begin
            w = iws[i];
            n = w[13] ? w[6] : w[2];
            old = e_p[n];
            if (!w[13]) e_p[n] = w[0] ? old - 16'h1 : old + 16'h1;
            a = w[13] ? old + 16'(signed'(w[5:0])) : (w[1] ? old : e_p[n]);
            issue(w);
            note(t + 1, 3, 33'h0b);
            note(t + 1, 4, 33'({e_p[1], e_p[0]}));
            if (old[15] == e_p[n][15] && old[15] == a[15])
                note(t + 2, 3, 33'({a[15], 3'b011}));
            e_acc = a[7:0] * 8'd37;
            e_z = (e_acc == 8'h00);
            note(t + 3, 0, 33'({e_z, e_c, e_acc}));
            idle(3);
        end
        idle(4);
        if (q.size() != 0) miscompares++;
        print_verdict();
    end
endmodule
